// ===== hdl/sfsp_front.sv
/*
 * Serial flash front end: bus framing, dual-lane read output, status word,
 * write latch, busy timing and block/hardware protection.
 * Assumes the serial clock is several times slower than MCLK_IN and that
 * SYS_RST_IN carries the power-on-reset indication.
 */
`timescale 1ns/1ps
`default_nettype none

module sfsp_front
	import sfsp_pkg::*;
#(
	parameter logic [15:0] WRITE_CYCLES = SFSP_WCYC_DEF
) (
	input  wire logic        MCLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        CLK_EN_IN,
	input  wire logic        SCLK_IN,
	input  wire logic        CS_N_IN,
	input  wire logic        WP_N_IN,
	input  wire logic        LANE_EVEN_IN,
	output logic             LANE_EVEN_OUT,
	output logic             LANE_EVEN_OE_OUT,
	input  wire logic        LANE_ODD_IN,
	output logic             LANE_ODD_OUT,
	output logic             LANE_ODD_OE_OUT,
	output logic [7:0]       STATUS_OUT,
	output logic             STANDBY_OUT,
	output logic             DEEP_PD_OUT,
	output logic             ARRAY_START_OUT,
	output logic [7:0]       ARRAY_OP_OUT,
	output logic [23:0]      ARRAY_ADDR_OUT
);
	logic [SFSP_PIN_W-1:0] pins_raw;
	logic [SFSP_PIN_W-1:0] pins_s;
	logic        sclk_p_q, cs_n_p_q, sel_q;
	logic [2:0]  bit_q, byte_q;
	logic [7:0]  sh_q, op_q, wdat_q;
	logic [23:0] addr_q;
	logic        lock_q, latch_q, busy_q, dpd_q;
	logic [2:0]  bp_q;
	logic [15:0] cnt_q;
	logic        odd_q, even_q, odd_oe_q, even_oe_q, start_q;
	logic [23:0] base_q;

	assign pins_raw = {WP_N_IN, LANE_ODD_IN, LANE_EVEN_IN, CS_N_IN, SCLK_IN};

	sfsp_sync u_sync (
		.clk_in (MCLK_IN),
		.rst_in (SYS_RST_IN),
		.en_in  (CLK_EN_IN),
		.d_in   (pins_raw),
		.q_out  (pins_s)
	);

	wire sclk_s = pins_s[SFSP_PIN_SCK];
	wire cs_n_s = pins_s[SFSP_PIN_CSN];
	wire si_s   = pins_s[SFSP_PIN_EVN];
	wire wp_n_s = pins_s[SFSP_PIN_WPN];

	// edges are tracked while idle too, so mode 3 idle-high clock is fine
	wire cs_fall    = cs_n_p_q & ~cs_n_s;
	wire cs_rise    = ~cs_n_p_q & cs_n_s;
	wire sclk_rise  = sel_q & ~sclk_p_q & sclk_s;
	wire sclk_fall  = sel_q & sclk_p_q & ~sclk_s;
	wire byte_end   = sclk_rise & (bit_q == SFSP_BIT_LAST);
	wire [7:0] shin = {sh_q[6:0], si_s};

	// commands that change state act only on a byte boundary at deselect
	wire exec_end = cs_rise & sel_q & (bit_q == SFSP_BIT_ZERO);
	wire accept   = exec_end & ~dpd_q & ~busy_q;
	wire hw_prot  = lock_q & ~wp_n_s;

	wire is_rdsr  = op_q == SFSP_OP_RDSR;
	wire is_read  = op_q == SFSP_OP_READ;
	wire is_fread = op_q == SFSP_OP_FREAD;
	wire is_dread = op_q == SFSP_OP_DREAD;
	wire is_pp    = op_q == SFSP_OP_PP;
	wire is_se    = op_q == SFSP_OP_SE;
	wire is_be32  = op_q == SFSP_OP_BE32;
	wire is_be64  = op_q == SFSP_OP_BE64;
	wire is_ce    = (op_q == SFSP_OP_CE1) | (op_q == SFSP_OP_CE2);

	// unit base address, aligned to the unit's own size
	wire [23:0] unit_mask = is_se   ? SFSP_MASK_SECT :
	                        is_be32 ? SFSP_MASK_HALF :
	                        is_be64 ? SFSP_MASK_BLK  : SFSP_MASK_SECT;
	wire [23:0] unit_base = addr_q & unit_mask;
	wire [7:0]  sect_idx  = {1'b0, unit_base[SFSP_SECT_MSB:SFSP_SECT_LSB]};
	// protected area grows up from sector 0, so checking the base suffices
	wire prot_hit = sect_idx < SFSP_PROT_LIM[bp_q];

	wire wr_ok   = accept & latch_q;
	wire do_status_write_cmd = wr_ok & (op_q == SFSP_OP_STATUS_WRITE_CMD)
	             & (byte_q == SFSP_NB_TWO) & ~hw_prot;
	wire do_pp   = wr_ok & is_pp & (byte_q >= SFSP_NB_DUMMY) & ~prot_hit;
	wire do_ers  = wr_ok & (is_se | is_be32 | is_be64)
	             & (byte_q == SFSP_NB_ADDR) & ~prot_hit;
	wire do_ce   = wr_ok & is_ce & (byte_q == SFSP_NB_ONE)
	             & (bp_q == SFSP_BP_NONE);
	wire do_arr  = do_pp | do_ers | do_ce;
	wire do_wren = accept & (op_q == SFSP_OP_WREN)
	             & (byte_q == SFSP_NB_ONE);
	wire do_wrdi = accept & (op_q == SFSP_OP_WRDI)
	             & (byte_q == SFSP_NB_ONE);
	wire do_dp   = accept & (op_q == SFSP_OP_DP)
	             & (byte_q == SFSP_NB_ONE);
	wire do_rdp  = exec_end & dpd_q & (op_q == SFSP_OP_RDP)
	             & (byte_q >= SFSP_NB_ONE);
	wire wr_done = busy_q & (cnt_q == SFSP_CNT_ONE);

	// reserved bits never stored, always read as zero
	wire [7:0] status_w = {lock_q, SFSP_ST_RSV, bp_q,
	                       latch_q, busy_q};

	// output phases; status is served even while busy
	wire out_st  = ~dpd_q & is_rdsr & (byte_q >= SFSP_NB_ONE);
	wire out_one = ~dpd_q & ((is_read & (byte_q >= SFSP_NB_ADDR))
	             | (is_fread & (byte_q >= SFSP_NB_DUMMY)));
	wire out_two = ~dpd_q & ~busy_q & is_dread
	             & (byte_q >= SFSP_NB_DUMMY);
	wire [2:0] obit = ~bit_q;
	wire [2:0] pbit_hi = {~bit_q[1:0], 1'b1};
	wire [2:0] pbit_lo = {~bit_q[1:0], 1'b0};
	wire odd_d  = out_two ? SFSP_READ_FILL[pbit_hi]
	            : out_st  ? status_w[obit] : SFSP_READ_FILL[obit];
	wire even_d = SFSP_READ_FILL[pbit_lo];

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			sclk_p_q <= 1'b0;
			cs_n_p_q <= 1'b0;
			sel_q    <= 1'b0;
		end else if (CLK_EN_IN) begin
			sclk_p_q <= sclk_s;
			cs_n_p_q <= cs_n_s;
			sel_q    <= cs_fall | (sel_q & ~cs_n_s);
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN || (CLK_EN_IN && cs_fall)) begin
			bit_q  <= SFSP_BIT_ZERO;
			byte_q <= SFSP_BIT_ZERO;
			sh_q   <= 8'h00;
			op_q   <= 8'h00;
			wdat_q <= 8'h00;
			addr_q <= 24'h000000;
		end else if (CLK_EN_IN && sclk_rise) begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= shin;
			if (byte_end && byte_q != SFSP_NB_MAX)
				byte_q <= byte_q + 3'h1;
			if (byte_end && byte_q == SFSP_BIT_ZERO)
				op_q <= shin;
			if (byte_end && byte_q == SFSP_NB_ONE)
				wdat_q <= shin;
			if (byte_end && byte_q >= SFSP_NB_ONE && byte_q < SFSP_NB_ADDR)
				addr_q <= {addr_q[15:0], shin};
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			lock_q <= 1'b0;
			bp_q   <= SFSP_BP_RST;
		end else if (CLK_EN_IN && do_status_write_cmd) begin
			lock_q <= wdat_q[SFSP_ST_LOCK];
			bp_q   <= wdat_q[SFSP_ST_BP_HI:SFSP_ST_BP_LO];
		end
	end

	// completion and a new enable cannot coincide: busy refuses commands
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN)
			latch_q <= 1'b0;
		else if (CLK_EN_IN && (wr_done || do_wrdi))
			latch_q <= 1'b0;
		else if (CLK_EN_IN && do_wren)
			latch_q <= 1'b1;
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			busy_q <= 1'b0;
			cnt_q  <= SFSP_CNT_ZERO;
		end else if (CLK_EN_IN && (do_status_write_cmd || do_arr)) begin
			busy_q <= 1'b1;
			cnt_q  <= WRITE_CYCLES;
		end else if (CLK_EN_IN && busy_q) begin
			busy_q <= ~wr_done;
			cnt_q  <= cnt_q - SFSP_CNT_ONE;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN)
			dpd_q <= 1'b0;
		else if (CLK_EN_IN && (do_dp || do_rdp))
			dpd_q <= do_dp;
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			start_q <= 1'b0;
			base_q  <= 24'h000000;
		end else if (CLK_EN_IN) begin
			start_q <= do_arr;
			if (do_arr)
				base_q <= is_ce ? 24'h000000 : unit_base;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN || (CLK_EN_IN && (cs_n_s || !sel_q))) begin
			odd_q     <= 1'b0;
			even_q    <= 1'b0;
			odd_oe_q  <= 1'b0;
			even_oe_q <= 1'b0;
		end else if (CLK_EN_IN && sclk_fall) begin
			odd_q     <= odd_d;
			even_q    <= even_d;
			odd_oe_q  <= out_st | out_one | out_two;
			even_oe_q <= out_two;
		end
	end

	assign LANE_ODD_OUT     = odd_q;
	assign LANE_ODD_OE_OUT  = odd_oe_q;
	assign LANE_EVEN_OUT    = even_q;
	assign LANE_EVEN_OE_OUT = even_oe_q;
	assign STATUS_OUT       = status_w;
	assign STANDBY_OUT      = cs_n_s & ~busy_q;
	assign DEEP_PD_OUT      = dpd_q;
	assign ARRAY_START_OUT  = start_q;
	assign ARRAY_OP_OUT     = op_q;
	assign ARRAY_ADDR_OUT   = base_q;

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN || !CLK_EN_IN);

	sequence s_write_start;
		CLK_EN_IN && (do_status_write_cmd || do_arr);
	endsequence
	sequence s_busy_run;
		busy_q [*8];
	endsequence

	a_latch_on_wren: assert property (do_wren |=> latch_q)
		else $error("write enable did not set latch");
	a_no_latch_refuse: assert property (
		(exec_end && !latch_q && !busy_q) |=>
		!busy_q && $stable(bp_q) && $stable(lock_q))
		else $error("write accepted without latch");
	a_busy_holds_run: assert property (
		s_write_start |=> s_busy_run)
		else $error("busy dropped early");
	a_busy_end_clear: assert property (
		$fell(busy_q) |-> !latch_q && $past(cnt_q) == SFSP_CNT_ONE)
		else $error("write end left latch set");
	a_hw_lock_guard: assert property (
		(exec_end && hw_prot && op_q == SFSP_OP_STATUS_WRITE_CMD) |=>
		$stable(bp_q) && $stable(lock_q))
		else $error("status changed under hardware lock");
	a_prot_area_reject: assert property (
		(exec_end && prot_hit && (is_se || is_be32 || is_be64)
		&& !busy_q) |=> !busy_q && !start_q)
		else $error("erase ran on protected area");
	a_dpd_ignore_cmd: assert property (
		(exec_end && dpd_q && op_q != SFSP_OP_RDP) |=>
		dpd_q && $stable(latch_q) && !busy_q)
		else $error("command acted in deep power-down");
	a_select_edge_only: assert property (
		$rose(sel_q) |-> $past(cs_n_p_q) && !$past(cs_n_s))
		else $error("selected without falling edge");
	a_dual_lane_pair: assert property (
		even_oe_q |-> odd_oe_q && is_dread)
		else $error("even lane driven outside dual read");
	a_shift_on_fall: assert property (
		$changed(odd_q) && odd_oe_q |-> $past(sclk_fall))
		else $error("output changed off a falling edge");
	a_reserved_zero: assert property (
		(sclk_fall && out_st && obit > SFSP_ST_BP_HI
		&& obit < SFSP_ST_LOCK) |=> !odd_q)
		else $error("reserved status bit shifted out as one");
endmodule // sfsp_front

`default_nettype wire

// ===== hdl/sfsp_pkg.sv
/*
 * Shared constants of the serial flash status/protect front end, plus the
 * pin synchroniser that the front end instantiates.
 * Assumes one system clock; pins arrive asynchronously to it.
 */
`timescale 1ns/1ps
`default_nettype none

package sfsp_pkg;
	// synchronised pin vector layout
	localparam int unsigned SFSP_PIN_W   = 5;
	localparam int unsigned SFSP_PIN_SCK = 0;
	localparam int unsigned SFSP_PIN_CSN = 1;
	localparam int unsigned SFSP_PIN_EVN = 2;
	localparam int unsigned SFSP_PIN_ODD = 3;
	localparam int unsigned SFSP_PIN_WPN = 4;
	localparam logic [SFSP_PIN_W-1:0] SFSP_PIN_RST = 5'h00;

	// instruction codes
	localparam logic [7:0] SFSP_OP_WREN  = 8'h06;
	localparam logic [7:0] SFSP_OP_WRDI  = 8'h04;
	localparam logic [7:0] SFSP_OP_RDSR  = 8'h05;
	localparam logic [7:0] SFSP_OP_STATUS_WRITE_CMD  = 8'h01;
	localparam logic [7:0] SFSP_OP_READ  = 8'h03;
	localparam logic [7:0] SFSP_OP_FREAD = 8'h0B;
	localparam logic [7:0] SFSP_OP_DREAD = 8'h3B;
	localparam logic [7:0] SFSP_OP_PP    = 8'h02;
	localparam logic [7:0] SFSP_OP_SE    = 8'h20;
	localparam logic [7:0] SFSP_OP_BE32  = 8'h52;
	localparam logic [7:0] SFSP_OP_BE64  = 8'hD8;
	localparam logic [7:0] SFSP_OP_CE1   = 8'hC7;
	localparam logic [7:0] SFSP_OP_CE2   = 8'h60;
	localparam logic [7:0] SFSP_OP_DP    = 8'hB9;
	localparam logic [7:0] SFSP_OP_RDP   = 8'hAB;

	// frame lengths in whole bytes, and bit positions within a byte
	localparam logic [2:0] SFSP_NB_ONE  = 3'h1;
	localparam logic [2:0] SFSP_NB_TWO  = 3'h2;
	localparam logic [2:0] SFSP_NB_ADDR = 3'h4;
	localparam logic [2:0] SFSP_NB_DUMMY = 3'h5;
	localparam logic [2:0] SFSP_NB_MAX  = 3'h7;
	localparam logic [2:0] SFSP_BIT_LAST = 3'h7;
	localparam logic [2:0] SFSP_BIT_ZERO = 3'h0;

	// status word fields
	localparam int unsigned SFSP_ST_BUSY  = 0;
	localparam int unsigned SFSP_ST_LATCH = 1;
	localparam int unsigned SFSP_ST_BP_LO = 2;
	localparam int unsigned SFSP_ST_BP_HI = 4;
	localparam int unsigned SFSP_ST_LOCK  = 7;
	localparam logic [1:0]  SFSP_ST_RSV   = 2'h0;
	localparam logic [2:0]  SFSP_BP_NONE  = 3'h0;
	localparam logic [2:0]  SFSP_BP_RST   = 3'h0;

	// array geometry: 4K sectors, 32K half blocks, 64K blocks
	localparam logic [23:0] SFSP_MASK_SECT = 24'hFFF000;
	localparam logic [23:0] SFSP_MASK_HALF = 24'hFF8000;
	localparam logic [23:0] SFSP_MASK_BLK  = 24'hFF0000;
	localparam int unsigned SFSP_SECT_LSB  = 12;
	localparam int unsigned SFSP_SECT_MSB  = 18;

	// protected sectors, counted from sector 0, per protect-range code
	localparam logic [7:0] SFSP_PROT_LIM [8] = '{8'h00, 8'h7E, 8'h7C,
		8'h78, 8'h70, 8'h60, 8'h40, 8'h80};

	localparam logic [7:0]  SFSP_READ_FILL = 8'hFF;
	localparam logic [15:0] SFSP_WCYC_DEF  = 16'h00C8;
	localparam logic [15:0] SFSP_CNT_ONE   = 16'h0001;
	localparam logic [15:0] SFSP_CNT_ZERO  = 16'h0000;
endpackage : sfsp_pkg

module sfsp_sync
	import sfsp_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  en_in,
	input  wire logic [SFSP_PIN_W-1:0] d_in,
	output logic      [SFSP_PIN_W-1:0] q_out
);
	logic [SFSP_PIN_W-1:0] meta_q;

	// reset to zero so a select pin held low reads as no edge
	genvar i;
	for (i = 0; i < SFSP_PIN_W; i++) begin : g_bit
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				meta_q[i] <= SFSP_PIN_RST[i];
				q_out[i]  <= SFSP_PIN_RST[i];
			end else if (en_in) begin
				meta_q[i] <= d_in[i];
				q_out[i]  <= meta_q[i];
			end
		end
	end
endmodule // sfsp_sync

`default_nettype wire

// ===== verif/sfsp_host.sv
/*
 * Behavioural serial bus host that frames instructions for the front end.
 * Assumes the bench calls xfer just after a rising edge of the 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sfsp_host (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out,
	input  wire logic odd_in,
	input  wire logic even_in
);
	bit         mode3 = 1'b0;
	logic [7:0] rx    = 8'h00;

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		si_out = 1'b0;
	end

	// clock toggles only inside a frame; idle level picks mode 0 or 3
	task automatic xfer(input logic [39:0] tx, input int nbits,
		input int nrd, input bit dual);
		int i;
		sclk_out = mode3;
		#40;
		cs_n_out = 1'b0;
		#40;
		for (i = 0; i < nbits + nrd * (dual ? 4 : 8); i++) begin
			sclk_out = 1'b0;
			// a released line flips so a stale bit never looks valid
			si_out = (i < nbits) ? tx[39 - i] : ~si_out;
			#40;
			sclk_out = 1'b1;
			#20;
			if (i >= nbits)
				rx = dual ? {rx[5:0], odd_in, even_in} : {rx[6:0], odd_in};
			#20;
		end
		sclk_out = mode3;
		#40;
		cs_n_out = 1'b1;
		#80;
	endtask
endmodule // sfsp_host
`default_nettype wire

// ===== verif/sfsp_front_tb.sv
/*
 * Self-checking bench of the serial flash status/protect front end.
 * Assumes the host model frames every instruction on the pins.
 */
`timescale 1ns/1ps
`default_nettype none

module sfsp_front_tb;
	localparam logic [15:0] WCYC = 16'h012C;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        wp_n    = 1'b1;
	logic        clk_en  = 1'b1;
	wire         sclk, cs_n, si, even_oe, even_d, odd_oe, odd_d, deep;
	wire         start, stby;
	wire  [7:0]  st, aop;
	wire  [23:0] aaddr;
	wire         even_w = even_oe ? even_d : si;
	// a released odd lane shows the inverse of the last bit the host took
	wire         odd_w  = odd_oe ? odd_d : ~i_sfsp_host.rx[0];
	wire  [23:0] st24   = {16'h0000, st};
	wire  [23:0] rx24   = {16'h0000, i_sfsp_host.rx};
	int          fails = 0, checks = 0, cyc = 0, starts = 0, busy_run = 0;
	logic [23:0] last_op, last_addr;
	bit          even_seen = 1'b0;

	sfsp_front #(
		.WRITE_CYCLES(WCYC)
	) i_sfsp_front (
		.MCLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(clk_en),
		.SCLK_IN(sclk), .CS_N_IN(cs_n), .WP_N_IN(wp_n),
		.LANE_EVEN_IN(even_w), .LANE_EVEN_OUT(even_d),
		.LANE_EVEN_OE_OUT(even_oe), .LANE_ODD_IN(odd_w),
		.LANE_ODD_OUT(odd_d), .LANE_ODD_OE_OUT(odd_oe), .STATUS_OUT(st),
		.STANDBY_OUT(stby), .DEEP_PD_OUT(deep), .ARRAY_START_OUT(start),
		.ARRAY_OP_OUT(aop), .ARRAY_ADDR_OUT(aaddr)
	);
	sfsp_host i_sfsp_host (
		.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si),
		.odd_in(odd_w), .even_in(even_w)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (st[0] === 1'b1)
			busy_run++;
		if (even_oe === 1'b1)
			even_seen = 1'b1;
		if (start === 1'b1) begin
			starts++;
			last_op = {16'h0000, aop};
			last_addr = aaddr;
		end
		if (cyc == 40000) begin
			fails++;
			$display("[FAIL] run length expected below 40000 seen %0d", cyc);
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic go(input logic [39:0] tx, input int n, input int nrd = 0,
		input bit dual = 1'b0);
		@(posedge clk);
		#1;
		i_sfsp_host.xfer(tx, n, nrd, dual);
	endtask

	task automatic idle();
		int i;
		for (i = 0; i < 1000 && st[0] !== 1'b0; i++)
			@(posedge clk);
		#1;
	endtask

	// select low since power-up: the first frame has no falling edge
	task automatic t_power_up();
		go(40'h0600000000, 8);
		chk("no select edge", 24'h000000, st24);
		chk("standby", 24'h000001, 24'(stby));
		$display("test power_up done");
	endtask

	task automatic t_latch();
		i_sfsp_host.mode3 = 1'b1;
		go(40'h0600000000, 8);
		chk("latch set", 24'h000002, st24);
		go(40'h0500000000, 8, 2);
		chk("status read", 24'h000002, rx24);
		i_sfsp_host.mode3 = 1'b0;
		go(40'h0400000000, 8);
		chk("latch clear", 24'h000000, st24);
		go(40'h0600000000, 7);
		chk("partial byte", 24'h000000, st24);
		go(40'h019C000000, 16);
		go(40'h2000100000, 32);
		chk("write no latch", 24'h000000, st24);
		chk("erase no latch", 24'h000000, 24'(starts));
		$display("test latch done");
	endtask

	task automatic t_status_write_cmd();
		go(40'h0600000000, 8);
		busy_run = 0;
		go(40'h01FC000000, 16);
		chk("busy set", 24'h000001, 24'(st[0]));
		chk("busy standby", 24'h000000, 24'(stby));
		go(40'h0500000000, 8, 1);
		chk("read while busy", 24'h00009F, rx24);
		idle();
		chk("status written", 24'h00009C, st24);
		checks++;
		if (busy_run < WCYC - 1 || busy_run > WCYC + 1) begin
			fails++;
			$display("[FAIL] busy length expected %0d seen %0d", WCYC, busy_run);
		end
		$display("test status_write_cmd done");
	endtask

	task automatic t_lock();
		wp_n = 1'b0;
		go(40'h0600000000, 8);
		go(40'h0100000000, 16);
		chk("locked", 24'h00009E, st24);
		wp_n = 1'b1;
		go(40'h0104000000, 16);
		idle();
		chk("unlocked", 24'h000004, st24);
		$display("test lock done");
	endtask

	task automatic t_protect();
		go(40'h0600000000, 8);
		go(40'h2007D12300, 32);
		chk("protected", 24'h000006, st24);
		chk("protected start", 24'h000000, 24'(starts));
		go(40'h2007E45600, 32);
		chk("erase busy", 24'h000007, st24);
		chk("sector base", 24'h07E000, last_addr);
		idle();
		chk("erase done", 24'h000004, st24);
		go(40'h0600000000, 8);
		go(40'h0207D000A5, 40);
		chk("program protected", 24'h000006, st24);
		go(40'h0207E123A5, 40);
		chk("program op", 24'h000002, last_op);
		chk("program base", 24'h07E000, last_addr);
		chk("program starts", 24'h000002, 24'(starts));
		idle();
		chk("program done", 24'h000004, st24);
		go(40'h0B07D12300, 40, 1);
		chk("fast read", 24'h0000FF, rx24);
		go(40'h0307D12300, 32, 1);
		chk("protected read", 24'h0000FF, rx24);
		go(40'h0600000000, 8);
		go(40'h0100000000, 16);
		idle();
		$display("test protect done");
	endtask

	task automatic t_erase();
		logic [39:0] tx [4] = '{40'h5205ABCD00, 40'hD805ABCD00,
			40'hC700000000, 40'h6000000000};
		logic [23:0] base [4] = '{24'h058000, 24'h050000, 24'h0, 24'h0};
		int i;
		for (i = 0; i < 4; i++) begin
			go(40'h0600000000, 8);
			go(tx[i], i < 2 ? 32 : 8);
			chk("unit op", {16'h0000, tx[i][39:32]}, last_op);
			chk("unit base", base[i], last_addr);
			idle();
			chk("latch after erase", 24'h000000, st24);
		end
		$display("test erase done");
	endtask

	// enable low must stop the write timer and the pin samplers alike
	task automatic t_freeze();
		go(40'h0600000000, 8);
		go(40'h0100000000, 16);
		clk_en = 1'b0;
		repeat (400) @(posedge clk);
		#1;
		chk("busy frozen", 24'h000003, st24);
		clk_en = 1'b1;
		idle();
		chk("thaw done", 24'h000000, st24);
		clk_en = 1'b0;
		go(40'h0600000000, 8);
		clk_en = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("frozen frame", 24'h000000, st24);
		$display("test freeze done");
	endtask

	task automatic t_read();
		even_seen = 1'b0;
		go(40'h3B00001000, 40, 1, 1'b1);
		chk("dual data", 24'h0000FF, rx24);
		chk("even lane driven", 24'h000001, 24'(even_seen));
		$display("test read done");
	endtask

	task automatic t_deep();
		go(40'hB900000000, 8);
		chk("deep entered", 24'h000001, 24'(deep));
		go(40'h0600000000, 8);
		chk("deep ignores", 24'h000000, st24);
		go(40'hAB00000000, 8);
		chk("deep left", 24'h000000, 24'(deep));
		$display("test deep done");
	endtask

	task automatic t_por();
		go(40'h0600000000, 8);
		rst = 1'b1;
		go(40'h0600000000, 8);
		chk("reset status", 24'h000000, st24);
		rst = 1'b0;
		repeat (4) @(posedge clk);
		go(40'h0500000000, 8, 1);
		chk("after reset", 24'h000000, rx24);
		$display("test por done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		t_power_up();
		t_latch();
		t_status_write_cmd();
		t_lock();
		t_protect();
		t_erase();
		t_freeze();
		t_read();
		t_deep();
		t_por();
		conclude();
	end
endmodule // sfsp_front_tb
`default_nettype wire
